// >>> wos_map.vh
// register map, field positions and reset values of the waveform output sequencer
// included by the top design file, the checker, the host model and the bench; holds definitions only
`ifndef WOS_MAP_VH
`define WOS_MAP_VH

// word indices on the avalon slave
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_DIVISOR 4'h2
`define REG_DELAY 4'h3
`define REG_COUNT 4'h4
`define REG_DATA 4'h5
`define REG_REF_SEL 4'h6
`define REG_OFS_SEL 4'h7
`define REG_LEVEL 4'h8

// control bits: 0..3 are self-clearing commands
`define C_START 0
`define C_STOP 1
`define C_SWUPD 2
`define C_QCLR 3
`define C_HWTIMED 4
`define C_BUFFERED 5
`define C_CONT 6
`define C_REGEN_LO 7
`define C_REGEN_HI 8
`define C_EXTSTROBE 9
`define C_STROBE_FALL 10
`define C_BSRC_LO 11
`define C_BSRC_HI 12
`define C_BEGIN_FALL 13
`define C_HOLD_EN 14
`define C_HOLD_ANALOG 15
`define C_HOLD_LOW 16
`define CTRL_KEEP_LO 4
`define CTRL_KEEP_HI 16

// status bits
`define S_RUNNING 0
`define S_ARMED 1
`define S_EMPTY 2
`define S_FULL 3
`define S_UNDERFLOW 4
`define S_HELD 5
`define S_LOADED 6

// continuous data modes
`define REGEN_HOST 2'h0
`define REGEN_QUEUE 2'h1
`define REGEN_NONE 2'h2

// begin trigger sources
`define BSRC_SW 2'h0
`define BSRC_PIN 2'h1
`define BSRC_ANALOG 2'h2

// reference kinds: 10 V, 5 V, external input, other channel
`define REF_10V 2'h0
`define REF_5V 2'h1
`define REF_EXT 2'h2
`define REF_CHAN 2'h3
// offset kinds: ground, 5 V, external input, other channel
`define OFS_GND 2'h0
`define OFS_5V 2'h1
`define OFS_EXT 2'h2
`define OFS_CHAN 2'h3

// data word: code in 15:0, channel in 17:16
`define D_CODE_HI 15
`define D_CH_LO 16
`define D_CH_HI 17

// reset values
`define DELAY_RST 32'h00000002
`define DIVISOR_RST 32'h00000064
`define COUNT_RST 32'h00000001

`endif

// >>> sample_queue.v
// first-in-first-out sample store between the host side and the converters
// assumes push and pop are single-cycle pulses; head data is valid while not empty
`timescale 1ns/1ns
module sample_queue #(
  parameter W = 64,
  parameter AW = 4
)(
  input wire clk,
  input wire rstn,
  input wire clear,
  input wire push,
  input wire [W-1:0] push_data,
  input wire pop,
  output wire [W-1:0] head,
  output wire empty,
  output wire full,
  output wire [AW:0] level
);
  localparam [AW:0] DEPTH = 1 << AW;
  reg [W-1:0] mem [0:(1<<AW)-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] cnt_reg;
  wire do_push;
  wire do_pop;

  assign empty = (cnt_reg == {(AW+1){1'b0}});
  assign full = (cnt_reg == DEPTH);
  assign level = cnt_reg;
  assign head = mem[rd_ptr_reg];
  // a push into a full queue is taken only when a pop frees the slot
  assign do_pop = pop && !empty;
  assign do_push = push && (!full || do_pop);

  // storage, written by index
  always @(posedge clk)
  begin
    if (do_push)
      mem[wr_ptr_reg] <= push_data;
  end

  // pointers and fill count
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end
    else if (clear)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (do_pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (do_push && !do_pop)
        cnt_reg <= cnt_reg + 1'b1;
      else if (do_pop && !do_push)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule

// >>> strobe_divider.v
// divides the update strobe base ticks into update strobes
// assumes tick is a one-cycle pulse; start reloads the first-strobe delay
`timescale 1ns/1ns
module strobe_divider #(
  parameter CW = 32
)(
  input wire clk,
  input wire rstn,
  input wire start,
  input wire enable,
  input wire tick,
  input wire [CW-1:0] divisor,
  input wire [CW-1:0] delay,
  output reg strobe
);
  reg [CW-1:0] cnt_reg;
  wire [CW-1:0] one;

  assign one = {{(CW-1){1'b0}}, 1'b1};

  // count base ticks; first strobe after delay ticks, then every divisor ticks
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_reg <= {CW{1'b0}};
      strobe <= 1'b0;
    end
    else
    begin
      strobe <= 1'b0;
      if (start)
        cnt_reg <= (delay == {CW{1'b0}}) ? one : delay;
      else if (enable && tick)
      begin
        if (cnt_reg <= one)
        begin
          strobe <= 1'b1;
          cnt_reg <= (divisor == {CW{1'b0}}) ? one : divisor;
        end
        else
          cnt_reg <= cnt_reg - one;
      end
    end
  end
endmodule

// >>> waveform_output_sequencer.v
// waveform output sequencer: avalon-mm register slave, sample queue and update pacing
// assumes all trigger and strobe inputs are synchronous to clk; base_tick is a pulse
// Function
// R1: two or four channels, one shared strobe
// R2: each strobe pops one sample to converters
// R3: sample queue between host and converters
// R4: fixed variant: ground offset, 10 V reference
// R5: selectable variant: per-channel 10/5 V/external reference
// R6: full variant: offset ground/5 V/external/channel
// R7: full variant: channel reference, never itself
// R8: software timed: one command, one update
// R9: hardware timed: divider or external strobe
// R10: buffered: queue feeds converters per update
// R11: finite mode stops after programmed count
// R12: continuous mode runs until stop
// R13: host reloads queue for standard regeneration
// R14: queue-local replay; writes refused after loading
// R15: non-regeneration: empty at update flags underflow
// R16: non-buffered: direct registers applied each strobe
// R17: usb variant forbids non-buffered hardware timing
// R18: begin and hold triggers, digital or analog
// R19: hold suppresses next updates, not current
// R20: begin starts divider; first strobe after delay
// R21: empty, full status; sticky underflow flag
//
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
`include "wos_map.vh"
module waveform_output_sequencer #(
  parameter NUM_CH = 4,
  parameter VARIANT = 2,
  parameter USB_VARIANT = 0,
  parameter QUEUE_AW = 4
)(
  input wire clk,
  input wire rstn,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire base_tick,
  input wire ext_strobe,
  input wire begin_pin,
  input wire hold_pin,
  input wire analog_cmp,
  output reg [NUM_CH*16-1:0] dac_code,
  output reg dac_load,
  output reg [NUM_CH*4-1:0] ref_sel,
  output reg [NUM_CH*4-1:0] offset_sel,
  output reg gen_active
);
  localparam FW = NUM_CH * 16;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_ARMED = 3'h2;
  localparam [2:0] ST_RUN = 3'h4;

  reg [2:0] state_reg;
  reg [31:0] ctrl_reg;
  reg [31:0] divisor_reg;
  reg [31:0] delay_reg;
  reg [31:0] count_reg;
  reg [31:0] remain_reg;
  reg [FW-1:0] stage_reg;
  reg underflow_reg;
  reg loaded_reg;
  reg begin_prev_reg;
  reg strobe_prev_reg;
  reg cmp_prev_reg;
  reg [31:0] rdata_next;
  integer i;

  wire [FW-1:0] q_head;
  wire [QUEUE_AW:0] q_level;
  wire q_empty;
  wire q_full;
  wire div_strobe;
  wire acc;
  wire wr_ctrl;
  wire wr_data;
  wire [1:0] regen;
  wire hwtimed;
  wire buffered;
  wire begin_evt;
  wire held;
  wire ext_edge;
  wire hw_strobe;
  wire upd_hw;
  wire upd_sw;
  wire do_pop;
  wire do_push;
  wire div_start;
  wire last_ch;
  wire [1:0] wr_ch;
  wire [FW-1:0] frame;
  wire q_clear;
  wire stop_cmd;
  wire finite_done;
  wire uf_evt;
  wire rotate;

  // a request is accepted on the edge where waitrequest is low
  assign acc = (avs_read || avs_write) && !avs_waitrequest;
  assign wr_ctrl = acc && avs_write && (avs_address == `REG_CTRL);
  assign wr_data = acc && avs_write && (avs_address == `REG_DATA);
  assign regen = ctrl_reg[`C_REGEN_HI:`C_REGEN_LO];
  assign hwtimed = ctrl_reg[`C_HWTIMED];
  // usb variant is always buffered when hardware timed
  assign buffered = ctrl_reg[`C_BUFFERED] || (USB_VARIANT != 0); // [R17]
  assign stop_cmd = wr_ctrl && avs_writedata[`C_STOP];
  assign q_clear = wr_ctrl && avs_writedata[`C_QCLR];
  assign rotate = do_pop && ctrl_reg[`C_CONT] && (regen == `REGEN_QUEUE); // [R14]

  // begin trigger: software command, pin edge or analog comparator rising edge
  assign begin_evt = (state_reg == ST_ARMED) && // [R18]
    (((ctrl_reg[`C_BSRC_HI:`C_BSRC_LO] == `BSRC_SW) && wr_ctrl && avs_writedata[`C_START]) ||
     ((ctrl_reg[`C_BSRC_HI:`C_BSRC_LO] == `BSRC_PIN) &&
      (ctrl_reg[`C_BEGIN_FALL] ? (begin_prev_reg && !begin_pin) : (!begin_prev_reg && begin_pin))) ||
     ((ctrl_reg[`C_BSRC_HI:`C_BSRC_LO] == `BSRC_ANALOG) && !cmp_prev_reg && analog_cmp));

  // hold trigger is level sensitive: pin with polarity, or comparator high
  assign held = ctrl_reg[`C_HOLD_EN] && // [R18]
    (ctrl_reg[`C_HOLD_ANALOG] ? analog_cmp : (hold_pin ^ ctrl_reg[`C_HOLD_LOW]));

  // pacing strobe from the divider or from the external strobe edge
  assign ext_edge = ctrl_reg[`C_STROBE_FALL] ? (strobe_prev_reg && !ext_strobe) :
    (!strobe_prev_reg && ext_strobe);
  assign hw_strobe = ctrl_reg[`C_EXTSTROBE] ? ext_edge : div_strobe; // [R9]
  // a held strobe is dropped; an update already issued completes
  assign upd_hw = (state_reg == ST_RUN) && hwtimed && hw_strobe && !held; // [R19]
  assign upd_sw = wr_ctrl && avs_writedata[`C_SWUPD] && !avs_writedata[`C_HWTIMED]; // [R8]
  assign div_start = begin_evt; // [R20]

  // queue traffic: pop on buffered updates; queue-local replay rotates the head back in
  assign do_pop = upd_hw && buffered && !q_empty; // [R2] [R10]
  assign uf_evt = upd_hw && buffered && q_empty && ctrl_reg[`C_CONT] &&
    (regen == `REGEN_NONE); // [R15]
  assign wr_ch = avs_writedata[`D_CH_HI:`D_CH_LO];
  assign last_ch = (wr_ch == NUM_CH - 1);
  assign do_push = (do_pop && ctrl_reg[`C_CONT] && (regen == `REGEN_QUEUE)) || // [R14]
    (wr_data && buffered && last_ch && !loaded_reg); // [R14]
  assign frame = rotate ? q_head : stage_next(stage_reg, wr_ch, avs_writedata[`D_CODE_HI:0]);
  assign finite_done = upd_hw && !ctrl_reg[`C_CONT] && (remain_reg <= 32'h00000001); // [R11]

  // place one channel code into the staging frame
  function [FW-1:0] stage_next;
    input [FW-1:0] cur;
    input [1:0] ch;
    input [15:0] code;
    integer k;
    begin
      stage_next = cur;
      for (k = 0; k < NUM_CH; k = k + 1)
        if (ch == k)
          stage_next[k*16 +: 16] = code;
    end
  endfunction

  // clean a selection field per variant; a channel naming itself is refused
  function [3:0] sel_fix;
    input [3:0] req;
    input [3:0] cur;
    input is_ref;
    input integer ch;
    begin
      if (VARIANT == 0)
        sel_fix = is_ref ? {2'h0, `REF_10V} : {2'h0, `OFS_GND}; // [R4]
      else if (VARIANT == 1 && !is_ref)
        sel_fix = {2'h0, `OFS_GND}; // [R4]
      else if (VARIANT == 1 && req[1:0] == `REF_CHAN)
        sel_fix = cur; // [R5]
      else if (req[1:0] == `REF_CHAN && (req[3:2] == ch || req[3:2] >= NUM_CH))
        sel_fix = cur; // [R7]
      else
        sel_fix = req; // [R5] [R6] [R7]
    end
  endfunction

  sample_queue #(
    .W(FW),
    .AW(QUEUE_AW)
  ) u_queue (
    .clk(clk),
    .rstn(rstn),
    .clear(q_clear),
    .push(do_push),
    .push_data(frame),
    .pop(do_pop),
    .head(q_head),
    .empty(q_empty),
    .full(q_full),
    .level(q_level)
  ); // [R3]

  strobe_divider #(
    .CW(32)
  ) u_div (
    .clk(clk),
    .rstn(rstn),
    .start(div_start),
    .enable(state_reg == ST_RUN),
    .tick(base_tick),
    .divisor(divisor_reg),
    .delay(delay_reg),
    .strobe(div_strobe)
  ); // [R20]

  // read mux, sampled while the slave still holds waitrequest
  always @*
  begin
    rdata_next = 32'h00000000;
    case (avs_address)
      `REG_CTRL: rdata_next = {15'h0000, ctrl_reg[`CTRL_KEEP_HI:`CTRL_KEEP_LO], 4'h0};
      `REG_STATUS:
      begin
        rdata_next[`S_RUNNING] = (state_reg == ST_RUN);
        rdata_next[`S_ARMED] = (state_reg == ST_ARMED);
        rdata_next[`S_EMPTY] = q_empty; // [R21]
        rdata_next[`S_FULL] = q_full; // [R21]
        rdata_next[`S_UNDERFLOW] = underflow_reg; // [R21]
        rdata_next[`S_HELD] = held;
        rdata_next[`S_LOADED] = loaded_reg;
      end
      `REG_DIVISOR: rdata_next = divisor_reg;
      `REG_DELAY: rdata_next = delay_reg;
      `REG_COUNT: rdata_next = count_reg;
      `REG_REF_SEL: rdata_next[NUM_CH*4-1:0] = ref_sel;
      `REG_OFS_SEL: rdata_next[NUM_CH*4-1:0] = offset_sel;
      `REG_LEVEL: rdata_next[QUEUE_AW:0] = q_level;
      default: rdata_next = 32'h00000000;
    endcase
  end

  // avalon handshake: one wait cycle, then one cycle with waitrequest low
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end
    else
    begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest)
        avs_readdata <= rdata_next;
    end
  end

  // configuration registers and selection fields
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_reg <= 32'h00000000;
      divisor_reg <= `DIVISOR_RST;
      delay_reg <= `DELAY_RST;
      count_reg <= `COUNT_RST;
      ref_sel <= {(NUM_CH*4){1'b0}};
      offset_sel <= {(NUM_CH*4){1'b0}};
    end
    else if (acc && avs_write)
    begin
      case (avs_address)
        `REG_CTRL: ctrl_reg[`CTRL_KEEP_HI:`CTRL_KEEP_LO] <= avs_writedata[`CTRL_KEEP_HI:`CTRL_KEEP_LO];
        `REG_DIVISOR: divisor_reg <= avs_writedata;
        `REG_DELAY: delay_reg <= avs_writedata; // [R20]
        `REG_COUNT: count_reg <= avs_writedata;
        `REG_REF_SEL:
          for (i = 0; i < NUM_CH; i = i + 1)
            ref_sel[i*4 +: 4] <= sel_fix(avs_writedata[i*4 +: 4], ref_sel[i*4 +: 4], 1'b1, i);
        `REG_OFS_SEL:
          for (i = 0; i < NUM_CH; i = i + 1)
            offset_sel[i*4 +: 4] <= sel_fix(avs_writedata[i*4 +: 4], offset_sel[i*4 +: 4], 1'b0, i);
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // generation sequence: idle, armed for the begin trigger, running
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= ST_IDLE;
      remain_reg <= 32'h00000000;
      loaded_reg <= 1'b0;
      gen_active <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
          if (wr_ctrl && avs_writedata[`C_START])
            state_reg <= ST_ARMED;
        ST_ARMED:
          if (stop_cmd)
            state_reg <= ST_IDLE;
          else if (begin_evt)
          begin
            state_reg <= ST_RUN; // [R18]
            remain_reg <= count_reg;
            loaded_reg <= ctrl_reg[`C_CONT] && (regen == `REGEN_QUEUE); // [R14]
          end
        ST_RUN:
          if (stop_cmd || finite_done) // [R11] [R12]
          begin
            state_reg <= ST_IDLE;
            loaded_reg <= 1'b0;
          end
          else if (upd_hw && !ctrl_reg[`C_CONT])
            remain_reg <= remain_reg - 32'h00000001; // [R11]
        default: state_reg <= ST_IDLE;
      endcase
      gen_active <= (state_reg == ST_RUN) && !stop_cmd && !finite_done;
    end
  end

  // staging frame, converter codes and the shared load pulse
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stage_reg <= {FW{1'b0}};
      dac_code <= {FW{1'b0}};
      dac_load <= 1'b0;
    end
    else
    begin
      if (wr_data && !loaded_reg)
        stage_reg <= stage_next(stage_reg, wr_ch, avs_writedata[`D_CODE_HI:0]);
      dac_load <= 1'b0;
      if (do_pop)
      begin
        dac_code <= q_head; // [R2] [R10]
        dac_load <= 1'b1; // [R1]
      end
      else if ((upd_hw && !buffered) || upd_sw)
      begin
        dac_code <= stage_reg; // [R8] [R16]
        dac_load <= 1'b1; // [R1]
      end
    end
  end

  // edge history and the sticky underflow flag; a new event beats the clear
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      begin_prev_reg <= 1'b0;
      strobe_prev_reg <= 1'b0;
      cmp_prev_reg <= 1'b0;
      underflow_reg <= 1'b0;
    end
    else
    begin
      begin_prev_reg <= begin_pin;
      strobe_prev_reg <= ext_strobe;
      cmp_prev_reg <= analog_cmp;
      if (uf_evt)
        underflow_reg <= 1'b1; // [R15] [R21]
      else if (begin_evt || (acc && avs_write && avs_address == `REG_STATUS &&
               avs_writedata[`S_UNDERFLOW]))
        underflow_reg <= 1'b0; // [R21]
    end
  end
endmodule

// >>> waveform_output_sequencer_sva.sv
// checker for the waveform output sequencer: bus handshake, update pulse and routing fields
// bound to every instance of the top module; one clock domain, reset active low
`timescale 1ns/1ns
`include "wos_map.vh"
module waveform_output_sequencer_sva #(
  parameter NUM_CH = 4,
  parameter VARIANT = 2
)(
  input wire clk,
  input wire rstn,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [NUM_CH*16-1:0] dac_code,
  input wire dac_load,
  input wire [NUM_CH*4-1:0] ref_sel,
  input wire [NUM_CH*4-1:0] offset_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // a pending request and an accepted software update command
  sequence s_req_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_sw_cmd;
    avs_write && !avs_waitrequest && avs_address == `REG_CTRL && avs_writedata[`C_SWUPD] && !avs_writedata[`C_HWTIMED];
  endsequence

  // bus answer timing and read data holding
  property p_wait_one;
    s_req_wait |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("request not answered after one wait cycle");
  property p_wait_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low for more than one cycle");
  property p_rd_hold;
    avs_waitrequest |-> $stable(avs_readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved outside a read answer");

  // converter update pulse and code holding
  property p_load_pulse;
    dac_load |=> !dac_load;
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("update pulse longer than one cycle");
  property p_code_hold;
    $changed(dac_code) |-> dac_load;
  endproperty
  a_code_hold: assert property (p_code_hold) else $error("converter codes changed without update");
  property p_sw_update;
    s_sw_cmd |=> dac_load;
  endproperty
  a_sw_update: assert property (p_sw_update) else $error("software update gave no converter load");

  // fixed selections on the reduced variants
  property p_var_ref;
    VARIANT == 0 |-> ref_sel == '0;
  endproperty
  a_var_ref: assert property (p_var_ref) else $error("reference selection not fixed");
  property p_var_ofs;
    VARIANT < 2 |-> offset_sel == '0;
  endproperty
  a_var_ofs: assert property (p_var_ofs) else $error("offset selection not fixed to ground");

  // a channel never feeds its own offset or reference
  property p_ref_self(int k);
    ref_sel[4*k +: 2] == 2'h3 |-> ref_sel[4*k+2 +: 2] != k;
  endproperty
  property p_ofs_self(int k);
    offset_sel[4*k +: 2] == 2'h3 |-> offset_sel[4*k+2 +: 2] != k;
  endproperty
  genvar k;
  for (k = 0; k < NUM_CH; k++)
  begin : g_ch
    a_ref_self: assert property (p_ref_self(k)) else $error("channel is its own reference");
    a_ofs_self: assert property (p_ofs_self(k)) else $error("channel is its own offset");
  end
endmodule

bind waveform_output_sequencer waveform_output_sequencer_sva #(.NUM_CH(NUM_CH), .VARIANT(VARIANT)) u_sva (
  .clk(clk),
  .rstn(rstn),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .dac_code(dac_code),
  .dac_load(dac_load),
  .ref_sel(ref_sel),
  .offset_sel(offset_sel)
);

// >>> host_model.sv
// host side model: avalon-mm master that loads sample frames and issues commands
// expects a slave answering with waitrequest low; one access at a time, bounded waits
`timescale 1ns/1ns
`include "wos_map.vh"
module host_model (
  input wire clk,
  input wire avs_waitrequest,
  input wire [31:0] avs_readdata,
  output logic [3:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata
);
  int stalls = 0;

  // idle bus at time zero
  initial
  begin
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
  end

  // one access: request held until waitrequest is sampled low
  task automatic access(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 64);
    q = avs_readdata;
    if (n >= 64)
      stalls++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // hands one frame over channel by channel; last channel pushes it
  task automatic load_frame(input logic [63:0] f);
    logic [31:0] q;
    for (int c = 0; c < 4; c++)
      access(1'b1, `REG_DATA, {14'h0, c[1:0], f[c*16 +: 16]}, q);
  endtask
endmodule

// >>> waveform_output_sequencer_bench.sv
// self-checking bench for the waveform output sequencer with four channels, full variant
// host model drives the register bus; the bench drives trigger and strobe pins
`timescale 1ns/1ns
`include "wos_map.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; $display("CHECK FAILED %0t got %0h expected %0h", $time, (a), (b)); end end
module waveform_output_sequencer_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic base_tick = 1'b0;
  logic ext_strobe = 1'b0;
  logic begin_pin = 1'b0;
  logic hold_pin = 1'b0;
  logic analog_cmp = 1'b0;
  wire [3:0] avs_address;
  wire avs_read;
  wire avs_write;
  wire [31:0] avs_writedata;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire [63:0] dac_code;
  wire dac_load;
  wire [15:0] ref_sel;
  wire [15:0] offset_sel;
  wire gen_active;
  int failures = 0;
  int checked = 0;
  int n;
  logic [31:0] seed = 32'h0000001B;
  logic [31:0] q;
  logic [63:0] fr [3];

  // clock and base tick pulse every other cycle
  always #2 clk = ~clk;
  always @(posedge clk) base_tick <= !base_tick && rstn;

  host_model host (.clk(clk), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata));
  waveform_output_sequencer dut (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .base_tick(base_tick), .ext_strobe(ext_strobe), .begin_pin(begin_pin),
    .hold_pin(hold_pin), .analog_cmp(analog_cmp), .dac_code(dac_code), .dac_load(dac_load), .ref_sel(ref_sel),
    .offset_sel(offset_sel), .gen_active(gen_active));

  // xorshift source of sample codes
  function logic [15:0] rnd16();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction

  // bus shorthands, bounded wait for an update, closing report
  task wr(input logic [3:0] a, input logic [31:0] d);
    host.access(1'b1, a, d, q);
  endtask
  task rd(input logic [3:0] a);
    host.access(1'b0, a, 32'h0, q);
  endtask
  task conclude;
    failures += host.stalls;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task wait_load;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (dac_load !== 1'b1 && n < 200);
    if (n >= 200)
    begin
      failures++;
      conclude;
    end
  endtask

  // overall limit on the run
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    conclude;
  end

  // main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd(`REG_DIVISOR);
    `CHK(q, `DIVISOR_RST)
    rd(`REG_DELAY);
    `CHK(q, `DELAY_RST)
    rd(`REG_COUNT);
    `CHK(q, `COUNT_RST)
    rd(4'hF);
    `CHK(q, 32'h0)
    rd(`REG_STATUS);
    `CHK(q[2], 1'b1)
    // software-timed update of staged codes, extreme values included
    fr[0] = {16'h7FFF, 16'h8000, rnd16(), 16'hFFFF};
    host.load_frame(fr[0]);
    wr(`REG_CTRL, 32'h4);
    wait_load;
    `CHK(dac_code, fr[0])
    // own-channel reference refused, other channel accepted
    wr(`REG_REF_SEL, 32'h33);
    wr(`REG_OFS_SEL, 32'h21);
    @(posedge clk);
    `CHK(ref_sel[7:0], 8'h30)
    `CHK(offset_sel[7:0], 8'h21)
    // finite buffered hardware-timed run of three frames
    wr(`REG_DIVISOR, 32'h3);
    wr(`REG_DELAY, 32'h2);
    wr(`REG_COUNT, 32'h3);
    wr(`REG_CTRL, 32'h28);
    for (int i = 0; i < 3; i++)
    begin
      fr[i] = {rnd16(), rnd16(), rnd16(), rnd16()};
      host.load_frame(fr[i]);
    end
    rd(`REG_LEVEL);
    `CHK(q, 32'h3)
    wr(`REG_CTRL, 32'h31);
    wr(`REG_CTRL, 32'h31);
    for (int i = 0; i < 3; i++)
    begin
      wait_load;
      `CHK(dac_code, fr[i])
    end
    for (n = 0; n < 20 && gen_active !== 1'b0; n++)
      @(posedge clk);
    `CHK(gen_active, 1'b0)
    rd(`REG_STATUS);
    `CHK(q[2], 1'b1)
    // queue-local replay of two frames, later writes refused
    wr(`REG_CTRL, 32'h28);
    host.load_frame(fr[0]);
    host.load_frame(fr[1]);
    wr(`REG_CTRL, 32'hF1);
    wr(`REG_CTRL, 32'hF1);
    for (int i = 0; i < 3; i++)
    begin
      wait_load;
      `CHK(dac_code, fr[i % 2])
    end
    host.load_frame(fr[2]);
    rd(`REG_LEVEL);
    `CHK(q, 32'h2)
    wr(`REG_CTRL, 32'h2);
    // continuous run without regeneration on an empty queue
    wr(`REG_CTRL, 32'h28);
    wr(`REG_CTRL, 32'h171);
    wr(`REG_CTRL, 32'h171);
    q = 32'h0;
    for (n = 0; n < 30 && q[4] !== 1'b1; n++)
      rd(`REG_STATUS);
    `CHK(q[4], 1'b1)
    wr(`REG_CTRL, 32'h2);
    wr(`REG_STATUS, 32'h10);
    rd(`REG_STATUS);
    `CHK(q[4], 1'b0)
    // unbuffered continuous run: pin begin, external strobe, hold pin drops strobes
    host.load_frame(fr[2]);
    wr(`REG_CTRL, 32'h4A51);
    @(posedge clk);
    begin_pin <= 1'b1;
    hold_pin <= 1'b1;
    n = 0;
    repeat (8)
    begin
      @(posedge clk);
      ext_strobe <= !ext_strobe;
      if (dac_load !== 1'b0)
        n++;
    end
    `CHK(n, 0)
    @(posedge clk);
    hold_pin <= 1'b0;
    ext_strobe <= 1'b1;
    wait_load;
    `CHK(dac_code, fr[2])
    `CHK(gen_active, 1'b1)
    wr(`REG_CTRL, 32'h2);
    @(posedge clk);
    `CHK(gen_active, 1'b0)
    conclude;
  end
endmodule
